// ==== shared/spi_port_consts.svh ====
// constants for the serial port block: offsets, field positions, reset values
// assumes it is included by the core file
`ifndef SPI_PORT_CONSTS_SVH
`define SPI_PORT_CONSTS_SVH
// register indices as printed; byte address is four times the index
`define IDX_DATA        8'h31
`define IDX_CTRL        8'h32
`define IDX_STAT        8'h33
// control fields
`define CTL_IRQ_EN      7
`define CTL_OUT_EN      6
`define CTL_RATE_DIV    5
`define CTL_MASTER      4
`define CTL_IDLE        3
`define CTL_PHASE       2
// status fields
`define ST_DONE         7
`define ST_WRITE_COLLISION_FLAG         6
`define ST_OVR          5
`define ST_MASTER_FAULT_FLAG         4
`define ST_SOD          2
`define ST_SSM          1
`define ST_SSI          0
`define CTRL_RESET      8'h00
`define STAT_RESET      8'h00
`define BITS_PER_XFER   4'h8
`endif

// ==== shared/spi_port_pkg.sv ====
// types shared by the serial port block
// assumes the constants header sits beside it
package spi_port_pkg;
   typedef enum logic [1:0] {
      XF_IDLE,
      XF_LEAD,
      XF_TRAIL
   } xfer_state_type;

   // avalon-mm slave request and answer
   typedef struct packed {
      logic        read;
      logic        write;
      logic [9:0]  address;
      logic [7:0]  writedata;
   } bus_req_type;

   typedef struct packed {
      logic        waitrequest;
      logic [31:0] readdata;
   } bus_rsp_type;

   // serial pins: two signals per two-way pin
   typedef struct packed {
      logic sck_o;
      logic sck_oe;
      logic mosi_o;
      logic mosi_oe;
      logic miso_o;
      logic miso_oe;
   } pin_out_type;

   typedef struct packed {
      xfer_state_type st;
      logic [7:0]  ctrl_reg;
      logic [7:0]  stat_reg;
      logic [7:0]  shift_reg;
      logic [7:0]  rx_buf_reg;
      logic [3:0]  bit_cnt_reg;
      logic [6:0]  div_cnt_reg;
      logic        stat_seen_reg;
      logic        master_fault_flag_seen_reg;
      logic        in_bit_reg;
      logic        sck_reg;
      logic        sck_s1, sck_s2, sck_s3;
      logic        ss_s1, ss_s2;
      logic        mosi_s1, mosi_s2;
      logic        miso_s1, miso_s2;
      logic        ack_reg;
      logic [7:0]  rdata_reg;
      logic        irq_reg;
      pin_out_type pins_reg;
   } state_type;
endpackage

// ==== core/spi_port.sv ====
// serial peripheral port: master or slave, byte wide, avalon-mm registers
// assumes pins are synchronous to nothing; clk is the 40 MHz cpu clock
`timescale 1ns/1ps
`include "spi_port_consts.svh"

// Function
// R1: interrupt when enabled and done, fault or overrun
// R2: output enable resets low, gates pin drive
// R3: master with select low sets fault, drops enables
// R4: master drives sck, swaps miso and mosi
// R5: idle level sets sck rest level
// R6: phase chooses first or second capture edge
// R7: master sck divides cpu clock per rate bits
// R8: rate bits ignored in slave mode
// R9: done flag set per byte, status-then-data clears
// R10: data writes ignored while done until status read
// R11: data write mid-transfer sets collision, no interrupt
// R12: byte while done sets overrun, status read clears
// R13: fault clears by status read then control write
// R14: output disable releases serial output
// R15: soft select uses soft level, pin freed
// R16: master data write starts one byte exchange
// R17: received byte copied to buffer, reads return buffer
// R18: data write loads shift register directly
// R19: software drops enable before changing idle level
// R20: partner uses same idle level and phase
// R21: data 31h, control 32h, status 33h, bit3 zero
// R22: on overrun buffer keeps first byte
// R23: fault blocks setting enable or master bits
// R24: eight bits msb first both directions
module spi_port (
   input  wire logic                       clk,
   input  wire logic                       rstn,
   input  wire spi_port_pkg::bus_req_type  bus_req,
   output spi_port_pkg::bus_rsp_type       bus_rsp,
   input  wire logic                       sck_i,
   input  wire logic                       mosi_i,
   input  wire logic                       miso_i,
   input  wire logic                       ss_n_i,
   output spi_port_pkg::pin_out_type       pins,
   output logic                            irq
);

   spi_port_pkg::state_type s_reg, s_next;

   // half period of sck in cpu clocks per rate code
   function automatic logic [6:0] half_div(input logic [2:0] code);
      unique case (code) // [R7]
         3'b100:  half_div = 7'h02;
         3'b000:  half_div = 7'h04;
         3'b001:  half_div = 7'h08;
         3'b110:  half_div = 7'h10;
         3'b010:  half_div = 7'h20;
         3'b011:  half_div = 7'h40;
         default: half_div = 7'h40; // unlisted codes take the slowest rate
      endcase
   endfunction

   logic [7:0] bidx;
   logic       hit_data, hit_ctrl, hit_stat, wr, rd;
   logic       ss_int, master, busy, sample_edge, shift_edge, tick;
   logic       s_rise, s_fall, edge_any, lead_edge;
   logic       m_cap, last_cap, cap_bit;
   logic [7:0] wdat;

   // ************************************************************
   // next-state logic
   // ************************************************************
   always_comb begin
      s_next = s_reg;
      bidx = bus_req.address[9:2];
      wr = bus_req.write;
      rd = bus_req.read;
      wdat = bus_req.writedata;
      hit_data = (bidx == `IDX_DATA); // [R21]
      hit_ctrl = (bidx == `IDX_CTRL);
      hit_stat = (bidx == `IDX_STAT);
      master = s_reg.ctrl_reg[`CTL_MASTER];
      busy = (s_reg.st != spi_port_pkg::XF_IDLE);
      // synchronisers: first stage only feeds the second
      s_next.sck_s1 = sck_i;
      s_next.sck_s2 = s_reg.sck_s1;
      s_next.sck_s3 = s_reg.sck_s2;
      s_next.ss_s1 = ss_n_i;
      s_next.ss_s2 = s_reg.ss_s1;
      s_next.mosi_s1 = mosi_i;
      s_next.mosi_s2 = s_reg.mosi_s1;
      s_next.miso_s1 = miso_i;
      s_next.miso_s2 = s_reg.miso_s1;
      // soft select replaces the pin when managed by software
      ss_int = s_reg.stat_reg[`ST_SSM] ? s_reg.stat_reg[`ST_SSI] : s_reg.ss_s2; // [R15]

      // bus: every access answered one cycle later, pulse acknowledge
      s_next.ack_reg = (rd | wr) & ~s_reg.ack_reg;
      tick = (rd | wr) & ~s_reg.ack_reg;
      if (tick && rd) begin
         if (hit_data)
            s_next.rdata_reg = s_reg.rx_buf_reg; // [R17]
         else if (hit_ctrl)
            s_next.rdata_reg = s_reg.ctrl_reg;
         else if (hit_stat)
            s_next.rdata_reg = s_reg.stat_reg & 8'hf7; // [R21]
         else
            s_next.rdata_reg = 8'h00;
      end

      // status access starts both clearing sequences; reading clears overrun
      if (tick && hit_stat) begin
         s_next.stat_seen_reg = s_reg.stat_reg[`ST_DONE] | s_reg.stat_reg[`ST_WRITE_COLLISION_FLAG];
         s_next.master_fault_flag_seen_reg = s_reg.stat_reg[`ST_MASTER_FAULT_FLAG]; // [R13]
         if (rd)
            s_next.stat_reg[`ST_OVR] = 1'b0; // [R12]
         if (wr)
            s_next.stat_reg[2:0] = wdat[2:0];
      end

      // control write; fault refuses enable and master unless clearing
      if (tick && wr && hit_ctrl) begin
         s_next.ctrl_reg = wdat;
         if (s_reg.stat_reg[`ST_MASTER_FAULT_FLAG] && !s_reg.master_fault_flag_seen_reg) begin
            s_next.ctrl_reg[`CTL_OUT_EN] = 1'b0; // [R23]
            s_next.ctrl_reg[`CTL_MASTER] = 1'b0;
         end
         if (s_reg.master_fault_flag_seen_reg) begin
            s_next.stat_reg[`ST_MASTER_FAULT_FLAG] = 1'b0; // [R13]
            s_next.master_fault_flag_seen_reg = 1'b0;
         end
      end

      // data access: closes the done/collision clearing sequence
      if (tick && hit_data) begin
         if (s_reg.stat_seen_reg) begin
            s_next.stat_reg[`ST_DONE] = 1'b0; // [R9]
            s_next.stat_reg[`ST_WRITE_COLLISION_FLAG] = 1'b0;
            s_next.stat_seen_reg = 1'b0;
         end
         if (wr) begin
            if (busy)
               s_next.stat_reg[`ST_WRITE_COLLISION_FLAG] = 1'b1; // [R11]
            else if (!s_reg.stat_reg[`ST_DONE] || s_reg.stat_seen_reg) begin // [R10]
               s_next.shift_reg = wdat; // [R18]
               if (master && s_reg.ctrl_reg[`CTL_OUT_EN]) begin
                  s_next.st = spi_port_pkg::XF_LEAD; // [R16]
                  s_next.bit_cnt_reg = 4'h0;
                  s_next.div_cnt_reg = 7'h00;
                  s_next.sck_reg = s_reg.ctrl_reg[`CTL_IDLE];
               end
            end
         end
      end

      // clock edges: master from divider, slave from synced pin
      s_rise = s_reg.sck_s2 & ~s_reg.sck_s3;
      s_fall = ~s_reg.sck_s2 & s_reg.sck_s3;
      edge_any = 1'b0;
      if (master) begin
         if (busy) begin
            s_next.div_cnt_reg = s_reg.div_cnt_reg + 7'h01;
            if (s_reg.div_cnt_reg == half_div({s_reg.ctrl_reg[`CTL_RATE_DIV],
                                               s_reg.ctrl_reg[1:0]}) - 7'h01) begin // [R7]
               s_next.div_cnt_reg = 7'h00;
               s_next.sck_reg = ~s_reg.sck_reg;
               edge_any = 1'b1;
            end
         end
      end else begin
         // slave ignores rate bits and follows the pin
         edge_any = (s_rise | s_fall) & ~ss_int & s_reg.ctrl_reg[`CTL_OUT_EN]; // [R8]
         if (!busy && edge_any) begin
            s_next.st = spi_port_pkg::XF_LEAD;
            s_next.bit_cnt_reg = 4'h0;
         end
      end
      // leading edge leaves idle level; phase picks capture edge
      lead_edge = master ? (s_reg.sck_reg == s_reg.ctrl_reg[`CTL_IDLE])
                         : ((s_rise & ~s_reg.ctrl_reg[`CTL_IDLE]) |
                            (s_fall & s_reg.ctrl_reg[`CTL_IDLE])); // [R5]
      sample_edge = edge_any & (lead_edge ^ s_reg.ctrl_reg[`CTL_PHASE]); // [R6]
      shift_edge = edge_any & ~sample_edge;
      // master takes miso one cycle after its own capture edge: at the fastest
      // rate the synchroniser would otherwise still show the previous bit
      m_cap = master & busy & (s_reg.div_cnt_reg == 7'h00) & (s_reg.bit_cnt_reg != 4'h0) &
              ((s_reg.sck_reg != s_reg.ctrl_reg[`CTL_IDLE]) ^ s_reg.ctrl_reg[`CTL_PHASE]);
      cap_bit = master ? s_reg.miso_s2 : s_reg.mosi_s2; // [R4]
      last_cap = master ? (s_reg.bit_cnt_reg == `BITS_PER_XFER)
                        : (s_reg.bit_cnt_reg == `BITS_PER_XFER - 4'h1);

      if (sample_edge)
         s_next.bit_cnt_reg = s_reg.bit_cnt_reg + 4'h1;
      if (m_cap | (~master & sample_edge)) begin
         s_next.in_bit_reg = cap_bit;
         if (s_reg.ctrl_reg[`CTL_PHASE] && last_cap)
            s_next.shift_reg = {s_reg.shift_reg[6:0], cap_bit}; // [R24]
      end
      if (shift_edge && (s_reg.bit_cnt_reg != 4'h0 || s_reg.ctrl_reg[`CTL_PHASE]))
         if (!s_reg.ctrl_reg[`CTL_PHASE] || s_reg.bit_cnt_reg != 4'h0)
            s_next.shift_reg = {s_reg.shift_reg[6:0], s_reg.in_bit_reg}; // [R24]

      // end of byte: last data edge done, copy to buffer
      if (busy && s_reg.bit_cnt_reg == `BITS_PER_XFER &&
          (s_reg.ctrl_reg[`CTL_PHASE] ? sample_edge | ~edge_any : shift_edge)) begin
         s_next.st = spi_port_pkg::XF_IDLE;
         s_next.bit_cnt_reg = 4'h0;
         s_next.sck_reg = s_reg.ctrl_reg[`CTL_IDLE];
         if (!s_reg.ctrl_reg[`CTL_PHASE])
            s_next.shift_reg = {s_reg.shift_reg[6:0], s_reg.in_bit_reg};
         if (s_reg.stat_reg[`ST_DONE] && !s_reg.stat_seen_reg)
            s_next.stat_reg[`ST_OVR] = 1'b1; // [R12] buffer kept [R22]
         else begin
            s_next.rx_buf_reg = s_reg.ctrl_reg[`CTL_PHASE] ? s_next.shift_reg
                               : {s_reg.shift_reg[6:0], s_reg.in_bit_reg}; // [R17]
            s_next.stat_reg[`ST_DONE] = 1'b1; // [R9]
         end
      end

      // mode fault: master sees select low
      if (master && !ss_int) begin
         s_next.stat_reg[`ST_MASTER_FAULT_FLAG] = 1'b1; // [R3]
         s_next.ctrl_reg[`CTL_OUT_EN] = 1'b0;
         s_next.ctrl_reg[`CTL_MASTER] = 1'b0;
         s_next.st = spi_port_pkg::XF_IDLE;
         s_next.sck_reg = s_reg.ctrl_reg[`CTL_IDLE];
      end
      s_next.stat_reg[3] = 1'b0; // [R21]
      // at rest the clock sits at its idle level, so a polarity change shows at once
      if (s_next.st == spi_port_pkg::XF_IDLE)
         s_next.sck_reg = s_next.ctrl_reg[`CTL_IDLE]; // [R5]

      // pins: enable gates everything, disable releases serial output
      s_next.pins_reg.sck_o = master ? s_next.sck_reg : 1'b0;
      s_next.pins_reg.sck_oe = s_next.ctrl_reg[`CTL_OUT_EN] & s_next.ctrl_reg[`CTL_MASTER]; // [R2]
      s_next.pins_reg.mosi_o = s_next.shift_reg[7]; // [R24]
      s_next.pins_reg.mosi_oe = s_next.ctrl_reg[`CTL_OUT_EN] & s_next.ctrl_reg[`CTL_MASTER] &
                                ~s_next.stat_reg[`ST_SOD]; // [R14]
      s_next.pins_reg.miso_o = s_next.shift_reg[7];
      s_next.pins_reg.miso_oe = s_next.ctrl_reg[`CTL_OUT_EN] & ~s_next.ctrl_reg[`CTL_MASTER] &
                                ~s_next.stat_reg[`ST_SOD] & ~ss_int; // [R4]
      s_next.irq_reg = s_next.ctrl_reg[`CTL_IRQ_EN] &
                       (s_next.stat_reg[`ST_DONE] | s_next.stat_reg[`ST_MASTER_FAULT_FLAG] |
                        s_next.stat_reg[`ST_OVR]); // [R1]
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_reg <= '0;
         s_reg.ctrl_reg <= `CTRL_RESET;
         s_reg.stat_reg <= `STAT_RESET;
         s_reg.sck_s1 <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs straight from flip-flops; waitrequest is the inverted ack
   always_comb begin
      bus_rsp.waitrequest = ~s_reg.ack_reg;
      bus_rsp.readdata = {24'h000000, s_reg.rdata_reg};
      pins = s_reg.pins_reg;
      irq = s_reg.irq_reg;
   end

   // ************************************************************
   // checks
   // ************************************************************
   property p_irq;
      @(posedge clk) disable iff (!rstn)
      1'b1 |-> irq == (s_reg.ctrl_reg[`CTL_IRQ_EN] &&
                       (s_reg.stat_reg[`ST_DONE] || s_reg.stat_reg[`ST_MASTER_FAULT_FLAG] ||
                        s_reg.stat_reg[`ST_OVR]));
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing"); // [R1]
   property p_fault;
      @(posedge clk) disable iff (!rstn)
      (master && !ss_int) |=> (s_reg.stat_reg[`ST_MASTER_FAULT_FLAG] && !s_reg.ctrl_reg[`CTL_MASTER]);
   endproperty
   a_fault: assert property (p_fault) else $error("fault not taken"); // [R3]
   property p_oe;
      @(posedge clk) disable iff (!rstn)
      !s_reg.ctrl_reg[`CTL_OUT_EN] |-> !pins.mosi_oe && !pins.sck_oe;
   endproperty
   a_oe: assert property (p_oe) else $error("pin driven while disabled"); // [R2]
   property p_res;
      @(posedge clk) disable iff (!rstn) 1'b1 |-> !s_reg.stat_reg[3];
   endproperty
   a_res: assert property (p_res) else $error("reserved bit set"); // [R21]
   property p_ack;
      @(posedge clk) disable iff (!rstn)
      (bus_req.read || bus_req.write) |-> ##[0:1] !bus_rsp.waitrequest;
   endproperty
   a_ack: assert property (p_ack) else $error("bus not answered"); // [R21]
   property p_sod;
      @(posedge clk) disable iff (!rstn)
      s_reg.stat_reg[`ST_SOD] |-> !pins.miso_oe;
   endproperty
   a_sod: assert property (p_sod) else $error("output not released"); // [R14]
   property p_idle;
      @(posedge clk) disable iff (!rstn)
      (master && !busy && !$past(busy)) |-> s_reg.sck_reg == s_reg.ctrl_reg[`CTL_IDLE];
   endproperty
   a_idle: assert property (p_idle) else $error("sck not at idle"); // [R5]
   property p_cnt;
      @(posedge clk) disable iff (!rstn) 1'b1 |-> s_reg.bit_cnt_reg <= `BITS_PER_XFER;
   endproperty
   a_cnt: assert property (p_cnt) else $error("bit count overrun"); // [R24]

   // flag, buffer and start checks; a data write seen on the bus this cycle
   sequence s_data_wr;
      tick && wr && hit_data;
   endsequence
   property p_load;
      @(posedge clk) disable iff (!rstn)
      s_data_wr ##0 (!busy && master && s_reg.ctrl_reg[`CTL_OUT_EN] && ss_int &&
                     (!s_reg.stat_reg[`ST_DONE] || s_reg.stat_seen_reg))
      |=> busy && s_reg.shift_reg == $past(wdat);
   endproperty
   a_load: assert property (p_load) else $error("byte not started"); // [R16] [R18]
   property p_write_collision_flag;
      @(posedge clk) disable iff (!rstn)
      s_data_wr ##0 busy |=> s_reg.stat_reg[`ST_WRITE_COLLISION_FLAG];
   endproperty
   a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged"); // [R11]
   property p_ignore;
      @(posedge clk) disable iff (!rstn)
      s_data_wr ##0 (!busy && s_reg.stat_reg[`ST_DONE] && !s_reg.stat_seen_reg)
      |=> $stable(s_reg.shift_reg);
   endproperty
   a_ignore: assert property (p_ignore) else $error("write taken while done"); // [R10]
   property p_done_hold;
      @(posedge clk) disable iff (!rstn)
      (s_reg.stat_reg[`ST_DONE] && !s_reg.stat_seen_reg) |=> s_reg.stat_reg[`ST_DONE];
   endproperty
   a_done_hold: assert property (p_done_hold) else $error("done cleared early"); // [R9]
   property p_keep;
      @(posedge clk) disable iff (!rstn)
      (s_reg.stat_reg[`ST_DONE] && !s_reg.stat_seen_reg) |=> $stable(s_reg.rx_buf_reg);
   endproperty
   a_keep: assert property (p_keep) else $error("buffer overwritten"); // [R22]
   property p_master_fault_flag_hold;
      @(posedge clk) disable iff (!rstn)
      (s_reg.stat_reg[`ST_MASTER_FAULT_FLAG] && !s_reg.master_fault_flag_seen_reg) |=> s_reg.stat_reg[`ST_MASTER_FAULT_FLAG];
   endproperty
   a_master_fault_flag_hold: assert property (p_master_fault_flag_hold) else $error("fault cleared early"); // [R13]
   property p_refuse;
      @(posedge clk) disable iff (!rstn)
      (s_reg.stat_reg[`ST_MASTER_FAULT_FLAG] && !s_reg.master_fault_flag_seen_reg && !s_reg.ctrl_reg[`CTL_OUT_EN])
      |=> !s_reg.ctrl_reg[`CTL_OUT_EN];
   endproperty
   a_refuse: assert property (p_refuse) else $error("enable set during fault"); // [R23]
   property p_slave_div;
      @(posedge clk) disable iff (!rstn)
      !master |=> $stable(s_reg.div_cnt_reg);
   endproperty
   a_slave_div: assert property (p_slave_div) else $error("divider ran as slave"); // [R8]
   property p_sck_slave;
      @(posedge clk) disable iff (!rstn)
      !master |-> !pins.sck_oe;
   endproperty
   a_sck_slave: assert property (p_sck_slave) else $error("slave drove sck"); // [R4]
   property p_miso_oe;
      @(posedge clk) disable iff (!rstn)
      !s_reg.ctrl_reg[`CTL_OUT_EN] |-> !pins.miso_oe;
   endproperty
   a_miso_oe: assert property (p_miso_oe) else $error("miso driven while disabled"); // [R2]
   property p_ack_pulse;
      @(posedge clk) disable iff (!rstn)
      !bus_rsp.waitrequest |=> bus_rsp.waitrequest;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("answer held too long"); // [R21]
endmodule

// ==== verif/spi_slave_model.sv ====
// far-side serial slave used while the port runs as master
// assumes the bench keeps its idle level and phase equal to the port's
`timescale 1ns/1ps
module spi_slave_model (
   input  wire logic       sck,
   input  wire logic       mosi,
   input  wire logic       sel,
   input  wire logic       clock_idle_level,
   input  wire logic       clock_capture_phase,
   input  wire logic       load,
   input  wire logic [7:0] tx,
   output logic            miso,
   output logic [7:0]      rx
);
   logic [7:0] sh;
   logic       first;
   // released line shows the inverse, so a stale bit never passes for data
   assign miso = sel ? sh[7] : ~sh[7];
   // capture on the leading edge for phase 0, trailing for phase 1
   always @(sck or posedge load) begin
      if (load) begin
         sh = tx;
         first = 1'b1;
      end else if (sel) begin
         if ((sck != clock_idle_level) ^ clock_capture_phase) rx = {rx[6:0], mosi};
         else if (!(clock_capture_phase && first)) sh = {sh[6:0], 1'b0};
         first = 1'b0;
      end
   end
endmodule

// ==== verif/spi_port_test.sv ====
// self-checking bench for the serial port: register bus, master and slave
// assumes the slave model file is compiled first
`timescale 1ns/1ps
module spi_port_test;
   // ****************************************
   // wiring
   // ****************************************
   logic                      clk, rstn, ss_n, tsck, tmosi, ld, sel, clock_idle_level, clock_capture_phase, irq, sck_q;
   logic [7:0]                stx, srx, r, got, half, cnt;
   logic                      sck_w, mosi_w, miso_w, smiso;
   spi_port_pkg::bus_req_type rq;
   spi_port_pkg::bus_rsp_type rs;
   spi_port_pkg::pin_out_type p;
   int                        fail_count, compares;
   // each wire follows whoever enables it
   assign sck_w  = p.sck_oe ? p.sck_o : tsck;
   assign mosi_w = p.mosi_oe ? p.mosi_o : tmosi;
   assign miso_w = p.miso_oe ? p.miso_o : smiso;
   spi_port dut (.clk(clk), .rstn(rstn), .bus_req(rq), .bus_rsp(rs), .sck_i(sck_w),
      .mosi_i(mosi_w), .miso_i(miso_w), .ss_n_i(ss_n), .pins(p), .irq(irq));
   spi_slave_model peer (.sck(sck_w), .mosi(mosi_w), .sel(sel), .clock_idle_level(clock_idle_level), .clock_capture_phase(clock_capture_phase),
      .load(ld), .tx(stx), .miso(smiso), .rx(srx));
   // half period of sck in cpu clocks, latched at every toggle
   always @(posedge clk) begin
      sck_q <= sck_w;
      cnt <= (sck_w != sck_q) ? 8'h01 : cnt + 8'h01;
      if (sck_w != sck_q) half <= cnt;
   end
   // ****************************************
   // helpers
   // ****************************************
   task automatic finish_test;
      if (fail_count == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic tmo;
      fail_count++;
      $display("ERROR %0t timeout", $time);
      finish_test;
   endtask
   // one avalon access, held until waitrequest is sampled low
   task automatic acc(input logic w, input logic [7:0] i, input logic [7:0] d);
      int n;
      rq <= '{read: !w, write: w, address: {i, 2'b00}, writedata: d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (rs.waitrequest !== 1'b0 && n < 99);
      if (n >= 99) tmo;
      r = rs.readdata[7:0];
      rq <= '0;
      @(posedge clk);
   endtask
   task automatic wirq;
      int n;
      for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge clk);
      if (n == 3000) tmo;
   endtask
   task automatic load(input logic [7:0] d);
      stx <= d;
      ld <= 1'b1;
      @(posedge clk);
      ld <= 1'b0;
   endtask
   // bench as master, mode 0, 16 cpu clocks per bit
   task automatic sbyte(input logic [7:0] d);
      int i;
      for (i = 7; i >= 0; i--) begin
         tmosi <= d[i];
         repeat (8) @(posedge clk);
         got = {got[6:0], miso_w};
         tsck <= 1'b1;
         repeat (8) @(posedge clk);
         tsck <= 1'b0;
      end
      repeat (8) @(posedge clk);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic reset_vals;
      chk({5'h0, p.sck_oe, p.mosi_oe, p.miso_oe}, 8'h00);
      acc(0, 8'h32, 8'h00);
      chk(r & 8'hf0, 8'h00);
      acc(0, 8'h33, 8'h00);
      chk(r, 8'h00);
      acc(0, 8'h30, 8'h00);
      chk(r, 8'h00);
      acc(1, 8'h32, 8'h10);
      chk({7'h0, p.sck_oe}, 8'h00);
   endtask
   // all six listed rate codes, all four clock modes
   task automatic rates;
      logic [2:0] code [6] = '{3'b100, 3'b000, 3'b001, 3'b110, 3'b010, 3'b011};
      logic [7:0] c;
      int         i;
      for (i = 0; i < 6; i++) begin
         clock_idle_level = i[1];
         clock_capture_phase = i[0];
         c = {2'b10, code[i][2], 1'b1, clock_idle_level, clock_capture_phase, code[i][1:0]};
         acc(1, 8'h32, c);
         acc(1, 8'h32, c | 8'h40);
         chk({7'h0, sck_w}, {7'h0, clock_idle_level});
         load(8'h3c + i);
         acc(1, 8'h31, 8'hc3 - i);
         wirq;
         chk(srx, 8'hc3 - i);
         chk(half, 8'(2 << i));
         chk({7'h0, sck_w}, {7'h0, clock_idle_level});
         acc(0, 8'h33, 8'h00);
         chk(r, 8'h80);
         acc(0, 8'h31, 8'h00);
         chk(r, 8'h3c + i);
         acc(0, 8'h33, 8'h00);
         chk(r | {7'h0, irq}, 8'h00);
      end
   endtask
   task automatic collide;
      clock_idle_level = 1'b0;
      clock_capture_phase = 1'b0;
      acc(1, 8'h32, 8'h90);
      acc(1, 8'h32, 8'hd0);
      load(8'h66);
      acc(1, 8'h31, 8'h5a);
      acc(1, 8'h31, 8'hff);
      wirq;
      acc(1, 8'h31, 8'h11);
      repeat (80) @(posedge clk);
      chk(srx, 8'h5a);
      acc(0, 8'h33, 8'h00);
      chk(r, 8'hc0);
      acc(0, 8'h31, 8'h00);
      chk(r, 8'h66);
      acc(0, 8'h33, 8'h00);
      chk(r, 8'h00);
   endtask
   task automatic slave_ovr;
      sel = 1'b0;
      acc(1, 8'h32, 8'h00);
      ss_n <= 1'b0;
      acc(1, 8'h32, 8'hc3);
      acc(1, 8'h31, 8'h81);
      sbyte(8'h5a);
      chk(got, 8'h81);
      sbyte(8'h99);
      acc(0, 8'h33, 8'h00);
      chk(r, 8'ha0);
      acc(0, 8'h31, 8'h00);
      chk(r, 8'h5a);
      acc(0, 8'h33, 8'h00);
      chk(r, 8'h00);
      ss_n <= 1'b1;
   endtask
   task automatic fault;
      acc(1, 8'h32, 8'hd0);
      ss_n <= 1'b0;
      wirq;
      acc(0, 8'h32, 8'h00);
      chk(r, 8'h80);
      acc(1, 8'h32, 8'hd0);
      acc(0, 8'h32, 8'h00);
      chk(r, 8'h80);
      chk({7'h0, p.sck_oe}, 8'h00);
      ss_n <= 1'b1;
      acc(0, 8'h33, 8'h00);
      chk(r, 8'h10);
      acc(1, 8'h32, 8'h00);
      acc(0, 8'h33, 8'h00);
      chk(r, 8'h00);
   endtask
   task automatic soft_sel;
      acc(1, 8'h33, 8'h07);
      ss_n <= 1'b0;
      acc(1, 8'h32, 8'h50);
      chk({6'h0, p.mosi_oe, p.sck_oe}, 8'h01);
      acc(0, 8'h33, 8'h00);
      chk(r, 8'h07);
      acc(1, 8'h33, 8'h03);
      chk({6'h0, p.mosi_oe, p.sck_oe}, 8'h03);
      acc(1, 8'h33, 8'h02);
      acc(0, 8'h33, 8'h00);
      chk(r, 8'h12);
      ss_n <= 1'b1;
   endtask
   // ****************************************
   // run
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      {rstn, tsck, tmosi, ld, clock_idle_level, clock_capture_phase} = '0;
      {ss_n, sel} = 2'b11;
      rq = '0;
      stx = 8'h00;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      reset_vals;
      rates;
      collide;
      slave_ovr;
      fault;
      soft_sel;
      finish_test;
   end
endmodule
